/* src/char_time_if.sv */
// character timing shared by the core and its two timers
`timescale 1ns/1ps
interface char_time_if;
	logic baudTick;
	logic [7:0] charTicks;
	logic fifoMode;
	modport src(output baudTick, output charTicks, output fifoMode);
	modport sink(input baudTick, input charTicks, input fifoMode);
endinterface

/* src/rx_timeout_timer.sv */
// receive fifo character time-out timer
`timescale 1ns/1ps
`include "uart_irq_cfg.svh"
module rx_timeout_timer
	import uart_irq_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// timing
	char_time_if.sink ct,
	// receive fifo activity
	input wire logic armed,
	input wire logic rxPush,
	input wire logic rxRead,
	input wire logic rxNotEmpty,
	// result
	output logic timeout
);
	logic [9:0] ticks;
	logic [9:0] limit;

	// four character times, in 16x ticks
	assign limit = 10'(ct.charTicks) << `TMO_SHIFT;

	// counts only while data waits and nobody touches the fifo
	always_ff @(posedge clk) begin
		if (reset || !armed || !rxNotEmpty) begin
			ticks <= '0;
			timeout <= 1'b0;
		end else if (timeout) begin
			if (rxRead) begin
				timeout <= 1'b0;
				ticks <= '0;
			end
		end else if (rxPush || rxRead) begin
			ticks <= '0;
		end else if (ct.baudTick) begin
			if (ticks == limit - 10'h001)
				timeout <= 1'b1;
			else
				ticks <= ticks + 10'h001;
		end
	end

	a_tmo_fires: assert property (@(posedge clk) disable iff (reset)
		$rose(timeout) |-> $past(ct.baudTick) && $past(ticks) == limit - 10'h001)
		else $error("time-out fired before four character times");
	a_tmo_clear: assert property (@(posedge clk) disable iff (reset)
		timeout && rxRead |=> !timeout && ticks == 10'h000)
		else $error("time-out not cleared by a read");
	a_tmo_restart: assert property (@(posedge clk) disable iff (reset)
		!timeout && (rxPush || rxRead) |=> ticks == 10'h000)
		else $error("timer not restarted by fifo activity");
endmodule

/* src/tx_empty_delay.sv */
// transmit fifo empty indication with its one-character delay
`timescale 1ns/1ps
`include "uart_irq_cfg.svh"
module tx_empty_delay
	import uart_irq_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// timing
	char_time_if.sink ct,
	// transmit fifo
	input wire logic [4:0] txLevel,
	input wire logic fifoToggle,
	// result
	output logic tx_holding_empty
);
	tx_holding_empty_state_e st;
	logic twoSeen;
	logic firstImm;
	logic [7:0] cnt;
	logic [7:0] delay;

	// one character time less the last stop bit
	assign delay = ct.charTicks - `TICKS_BIT;
	assign tx_holding_empty = (st == TX_EMPTY) && (txLevel == 5'h00);

	// empty indication state
	always_ff @(posedge clk) begin
		if (reset) begin
			st <= TX_EMPTY;
			cnt <= '0;
		end else begin
			unique case (st)
				TX_BUSY: if (txLevel == 5'h00) begin
					if (!ct.fifoMode || twoSeen || firstImm || fifoToggle) begin
						st <= TX_EMPTY;
					end else begin
						st <= TX_DELAY;
						cnt <= '0;
					end
				end
				TX_DELAY: if (txLevel != 5'h00) begin
					st <= TX_BUSY;
				// a fifo change cuts the delay short
				end else if (fifoToggle) begin
					st <= TX_EMPTY;
				end else if (ct.baudTick) begin
					if (cnt == delay - 8'h01)
						st <= TX_EMPTY;
					else
						cnt <= cnt + 8'h01;
				end
				TX_EMPTY: if (txLevel != 5'h00) begin
					st <= TX_BUSY;
				end
				default: st <= TX_EMPTY;
			endcase
		end
	end

	// two bytes held since last empty
	always_ff @(posedge clk) begin
		if (reset || st == TX_EMPTY)
			twoSeen <= 1'b0;
		else if (txLevel >= 5'h02)
			twoSeen <= 1'b1;
	end

	// a toggle meeting an empty fifo is used at once by the state above;
	// one arriving while shown empty or still busy waits for the next empty
	always_ff @(posedge clk) begin
		if (reset)
			firstImm <= 1'b0;
		else if (st != TX_EMPTY && txLevel == 5'h00)
			firstImm <= 1'b0;
		else if (fifoToggle)
			firstImm <= 1'b1;
	end

	a_tx_holding_empty_delay: assert property (@(posedge clk) disable iff (reset)
		st == TX_DELAY && txLevel == 5'h00 && ct.baudTick && cnt == delay - 8'h01 ##1 txLevel == 5'h00 |-> tx_holding_empty)
		else $error("delayed empty indication late");
	a_tx_holding_empty_imm: assert property (@(posedge clk) disable iff (reset)
		st == TX_BUSY && txLevel == 5'h00 && (firstImm || fifoToggle) ##1 txLevel == 5'h00 |-> tx_holding_empty)
		else $error("first empty after fifo change was delayed");
	a_tx_holding_empty_full: assert property (@(posedge clk) disable iff (reset)
		txLevel != 5'h00 |-> !tx_holding_empty ##1 st != TX_EMPTY)
		else $error("empty shown with bytes in fifo");
endmodule

/* src/uart_irq_cfg.svh */
// register map, codes and timing counts of the serial interrupt block
`ifndef UART_IRQ_CFG_SVH
`define UART_IRQ_CFG_SVH
`define A_DATA 8'h00
`define A_IEN 8'h04
`define A_IID 8'h08
`define A_LFC 8'h0c
`define A_LST 8'h14
`define A_MST 8'h18
`define IID_NONE 4'h1
`define IID_LINE 4'h6
`define IID_RXD 4'h4
`define IID_TMO 4'hc
`define IID_THR 4'h2
`define IID_MDM 4'h0
`define TRIG_L0 5'h01
`define TRIG_L1 5'h04
`define TRIG_L2 5'h08
`define TRIG_L3 5'h0e
`define TICKS_BIT 8'h10
`define TICKS_HALF 8'h08
`define BASE_BITS 8'h07
`define TMO_SHIFT 2
`define STOP_ONE 3'h2
`define STOP_ONEHALF 3'h3
`define STOP_TWO 3'h4
`define WL_FIVE 2'h0
`endif

/* src/uart_irq_core.sv */
// interrupt, fifo status and line format logic of the serial element
//
// Our own choices: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
`include "uart_irq_cfg.svh"
module uart_irq_core
	import uart_irq_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// receive datapath, same clock
	input wire logic rxPush,
	input wire logic [4:0] rxLevel,
	input wire logic [7:0] rxData,
	input wire logic rxFifoErr,
	input wire logic lineErrEvent,
	input wire logic [3:0] lineErrBits,
	// transmit datapath, same clock
	input wire logic [4:0] txLevel,
	input wire logic txShiftBusy,
	// modem status and baud generator
	input wire logic modemChange,
	input wire logic [7:0] modemStatus,
	input wire logic baudTick,
	// datapath controls
	output logic rxRead,
	output logic txWrite,
	output logic [7:0] txData,
	output logic fifoOn,
	output logic rxFifoClear,
	output logic txFifoClear,
	output logic [1:0] wordLen,
	output logic [2:0] txStopHalves,
	// interrupt
	output logic irqOut
);
	char_time_if ct();

	logic [3:0] ien;
	logic [1:0] trigSel;
	logic [7:0] lfc;
	logic linePend;
	logic modemPend;
	logic threPend;
	logic threD;
	logic ienTxD;
	logic [3:0] errLatch;
	logic fifoToggle;
	logic dWrite;
	logic [7:0] dAddr;
	logic addrPhase;
	logic rdData;
	logic rdIid;
	logic rdLst;
	logic rdMst;
	logic wrData;
	logic timeout;
	logic tx_holding_empty;
	logic rxAvail;
	logic txAllEmpty;
	logic [3:0] iidCode;
	logic [7:0] lineState;
	logic [7:0] extraStop;

	// trigger level select to byte count
	function automatic logic [4:0] trigLevel(input logic [1:0] sel);
		logic [4:0] lvl;
		lvl = `TRIG_L0;
		unique case (sel)
			2'h0: lvl = `TRIG_L0;
			2'h1: lvl = `TRIG_L1;
			2'h2: lvl = `TRIG_L2;
			2'h3: lvl = `TRIG_L3;
		endcase
		return lvl;
	endfunction

	// priority encoder, also read back through the identification register
	function automatic logic [3:0] iidOf(input logic pLine, input logic pRx, input logic pTmo,
			input logic pThr, input logic pMdm);
		logic [3:0] c;
		if (pLine)
			c = `IID_LINE;
		else if (pRx)
			c = `IID_RXD;
		else if (pTmo)
			c = `IID_TMO;
		else if (pThr)
			c = `IID_THR;
		else if (pMdm)
			c = `IID_MDM;
		else
			c = `IID_NONE;
		return c;
	endfunction

	// character time in 16x ticks; the second stop bit counts toward it
	// stop select shapes transmit and the character time of both timers
	always_comb begin
		extraStop = 8'h00;
		if (lfc[2])
			extraStop = (lfc[1:0] == `WL_FIVE) ? `TICKS_HALF : `TICKS_BIT;
	end

	assign ct.baudTick = baudTick;
	assign ct.charTicks = ((`BASE_BITS + 8'(lfc[1:0])) * `TICKS_BIT) + extraStop;
	assign ct.fifoMode = fifoOn;

	// armed only in fifo interrupt mode
	rx_timeout_timer u_tmo (
		.clk(clk),
		.reset(reset),
		.ct(ct),
		.armed(fifoOn && ien[0]),
		.rxPush(rxPush),
		.rxRead(rdData),
		.rxNotEmpty(rxLevel != 5'h00),
		.timeout(timeout)
	);

	tx_empty_delay u_tx_holding_empty (
		.clk(clk),
		.reset(reset),
		.ct(ct),
		.txLevel(txLevel),
		.fifoToggle(fifoToggle),
		.tx_holding_empty(tx_holding_empty)
	);

	// bus decode; reads take their side effects in the address phase
	assign addrPhase = hsel && htrans[1] && hready;
	assign rdData = addrPhase && !hwrite && haddr[7:0] == `A_DATA;
	assign rdIid = addrPhase && !hwrite && haddr[7:0] == `A_IID;
	assign rdLst = addrPhase && !hwrite && haddr[7:0] == `A_LST;
	assign rdMst = addrPhase && !hwrite && haddr[7:0] == `A_MST;
	assign wrData = dWrite && dAddr == `A_DATA;

	assign rxAvail = fifoOn ? (rxLevel >= trigLevel(trigSel)) : (rxLevel != 5'h00);
	assign txAllEmpty = tx_holding_empty && !txShiftBusy;

	assign iidCode = iidOf(ien[2] && linePend, ien[0] && rxAvail, timeout,
		ien[1] && threPend, ien[3] && modemPend);

	// data ready while fifo holds data
	assign lineState = {rxFifoErr && fifoOn, txAllEmpty, tx_holding_empty, errLatch, rxLevel != 5'h00};

	// address phase capture; one write data phase follows
	always_ff @(posedge clk) begin
		if (reset) begin
			dWrite <= 1'b0;
			dAddr <= 8'h00;
		end else begin
			dWrite <= addrPhase && hwrite;
			dAddr <= haddr[7:0];
		end
	end

	// read data is ready at the first data-phase edge, so no wait states
	always_ff @(posedge clk) begin
		if (reset) begin
			hrdata <= 32'h0000_0000;
		end else if (addrPhase && !hwrite) begin
			unique case (haddr[7:0])
				`A_DATA: hrdata <= {24'h00_0000, rxData};
				`A_IEN: hrdata <= {28'h000_0000, ien};
				`A_IID: hrdata <= {24'h00_0000, fifoOn, fifoOn, 2'h0, iidCode};
				`A_LFC: hrdata <= {24'h00_0000, lfc};
				`A_LST: hrdata <= {24'h00_0000, lineState};
				`A_MST: hrdata <= {24'h00_0000, modemStatus};
				default: hrdata <= 32'h0000_0000;
			endcase
		end
	end

	// ready once out of reset, always okay
	always_ff @(posedge clk) begin
		if (reset) begin
			hreadyout <= 1'b0;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// receive buffer read and holding register write strobes
	always_ff @(posedge clk) begin
		if (reset) begin
			rxRead <= 1'b0;
			txWrite <= 1'b0;
			txData <= 8'h00;
		end else begin
			rxRead <= rdData;
			txWrite <= wrData;
			if (wrData)
				txData <= hwdata[7:0];
		end
	end

	// interrupt enable register
	always_ff @(posedge clk) begin
		if (reset)
			ien <= 4'h0;
		else if (dWrite && dAddr == `A_IEN)
			ien <= hwdata[3:0];
	end

	// fifo setup: other bits only program with the enable bit set
	always_ff @(posedge clk) begin
		if (reset) begin
			fifoOn <= 1'b0;
			trigSel <= 2'h0;
			fifoToggle <= 1'b0;
			rxFifoClear <= 1'b0;
			txFifoClear <= 1'b0;
		end else begin
			fifoToggle <= 1'b0;
			rxFifoClear <= 1'b0;
			txFifoClear <= 1'b0;
			if (dWrite && dAddr == `A_IID) begin
				fifoOn <= hwdata[0];
				// changing the enable empties both fifos
				if (hwdata[0] != fifoOn) begin
					fifoToggle <= 1'b1;
					rxFifoClear <= 1'b1;
					txFifoClear <= 1'b1;
				end
				if (hwdata[0]) begin
					trigSel <= hwdata[7:6];
					rxFifoClear <= hwdata[1] || (hwdata[0] != fifoOn);
					txFifoClear <= hwdata[2] || (hwdata[0] != fifoOn);
				end
			end
		end
	end

	// line format register and transmit stop length
	always_ff @(posedge clk) begin
		if (reset) begin
			lfc <= 8'h00;
		end else if (dWrite && dAddr == `A_LFC) begin
			lfc <= hwdata[7:0];
		end
	end
	assign wordLen = lfc[1:0];

	always_ff @(posedge clk) begin
		if (reset)
			txStopHalves <= `STOP_ONE;
		else if (!lfc[2])
			txStopHalves <= `STOP_ONE;
		else if (lfc[1:0] == `WL_FIVE)
			txStopHalves <= `STOP_ONEHALF;
		else
			txStopHalves <= `STOP_TWO;
	end

	// line errors stick until line state is read; a new error wins
	// errors latch as in interrupt mode
	always_ff @(posedge clk) begin
		if (reset) begin
			errLatch <= 4'h0;
			linePend <= 1'b0;
		end else if (lineErrEvent) begin
			errLatch <= (rdLst ? 4'h0 : errLatch) | lineErrBits;
			linePend <= 1'b1;
		end else if (rdLst) begin
			errLatch <= 4'h0;
			linePend <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (reset)
			modemPend <= 1'b0;
		else if (modemChange)
			modemPend <= 1'b1;
		else if (rdMst)
			modemPend <= 1'b0;
	end

	// empty edge or a fresh enable raises the transmit source
	always_ff @(posedge clk) begin
		if (reset) begin
			threD <= 1'b1;
			ienTxD <= 1'b0;
		end else begin
			threD <= tx_holding_empty;
			ienTxD <= ien[1];
		end
	end

	// write or own identification read clears
	always_ff @(posedge clk) begin
		if (reset)
			threPend <= 1'b0;
		else if (tx_holding_empty && (!threD || (ien[1] && !ienTxD)))
			threPend <= 1'b1;
		else if (wrData || (rdIid && iidCode == `IID_THR) || !tx_holding_empty)
			threPend <= 1'b0;
	end

	always_ff @(posedge clk) begin
		if (reset)
			irqOut <= 1'b0;
		else
			irqOut <= iidCode != `IID_NONE;
	end

	sequence s_iidRead;
		addrPhase && !hwrite && haddr[7:0] == `A_IID;
	endsequence
	sequence s_lstRead;
		addrPhase && !hwrite && haddr[7:0] == `A_LST;
	endsequence

	a_iid_layout: assert property (@(posedge clk) disable iff (reset)
		s_iidRead |=> hrdata[7:6] == {2{$past(fifoOn)}} && hrdata[5:4] == 2'h0)
		else $error("identification upper bits wrong");
	a_iid_pending: assert property (@(posedge clk) disable iff (reset)
		s_iidRead |=> hrdata[0] == !$past(ien[2] && linePend || ien[0] && rxAvail || timeout
			|| ien[1] && threPend || ien[3] && modemPend))
		else $error("identification bit 0 disagrees with pending state");
	a_line_first: assert property (@(posedge clk) disable iff (reset)
		ien[2] && linePend |-> iidCode == `IID_LINE)
		else $error("line status not highest priority");
	a_tmo_code: assert property (@(posedge clk) disable iff (reset)
		iidCode[3] |-> fifoOn && timeout && iidCode[2])
		else $error("time-out code outside fifo mode");
	a_ien_upper: assert property (@(posedge clk) disable iff (reset)
		addrPhase && !hwrite && haddr[7:0] == `A_IEN |=> hrdata[7:4] == 4'h0)
		else $error("enable upper bits not zero");
	a_polled_quiet: assert property (@(posedge clk) disable iff (reset)
		ien == 4'h0 [*3] |-> !irqOut)
		else $error("interrupt raised with all enables clear");
	a_thr_clear: assert property (@(posedge clk) disable iff (reset)
		wrData && threD && !(ien[1] && !ienTxD) |=> !threPend)
		else $error("transmit source not cleared by write");
	a_ready_bit: assert property (@(posedge clk) disable iff (reset)
		s_lstRead |=> hrdata[0] == ($past(rxLevel) != 5'h00))
		else $error("data ready does not follow fifo fill");
	a_stop_half: assert property (@(posedge clk) disable iff (reset)
		lfc[2] && lfc[1:0] == `WL_FIVE |=> txStopHalves == `STOP_ONEHALF)
		else $error("five-bit stop length wrong");
	a_trig_level: assert property (@(posedge clk) disable iff (reset)
		fifoOn && ien[0] && !(ien[2] && linePend) && rxLevel >= trigLevel(trigSel) |-> iidCode == `IID_RXD)
		else $error("trigger level interrupt missing");
endmodule

/* src/uart_irq_pkg.sv */
// shared types of the serial interrupt block
package uart_irq_pkg;
	typedef enum logic [1:0] {TX_BUSY = 2'h0, TX_DELAY = 2'h1, TX_EMPTY = 2'h3} tx_holding_empty_state_e;
endpackage

/* verif/host_bus_model.sv */
// host-side ahb-lite master that issues single word transfers
`timescale 1ns/1ps
module host_bus_model (
	// clock
	input wire logic clk,
	// bus answer
	input wire logic hready,
	input wire logic [31:0] hrdata,
	// bus request
	output logic hsel,
	output logic [31:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [2:0] hsize,
	output logic [31:0] hwdata
);
	// bus idle at time zero; only whole words are ever moved
	initial begin
		hsel = 1'b1;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
	end

	// address phase held until hready, then data phase held until hready
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
		@(posedge clk);
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {24'h0, a};
		do @(posedge clk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clk); while (hready !== 1'b1);
		rd = hrdata;
		// released data lines must not keep showing the old word
		hwdata <= ~wd;
	endtask
endmodule

/* verif/uart_irq_core_bench.sv */
// self-checking bench of the serial interrupt core
`timescale 1ns/1ps
`include "uart_irq_cfg.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
	$display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module uart_irq_core_bench;
	import uart_irq_pkg::*;
	// four character times of 10 bits, and one less the stop bit
	localparam int TMO = 4 * 16 * 10;
	localparam int TXD = 16 * 9;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic hsel, hwrite, hreadyout, hresp, rxRead, txWrite, fifoOn, rxFifoClear, txFifoClear, irqOut;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans, wordLen;
	logic [2:0] hsize, txStopHalves;
	logic [7:0] txData, lastTx;
	logic rxPush = 1'b0, rxFifoErr = 1'b0, lineErrEvent = 1'b0, modemChange = 1'b0, baudTick = 1'b0;
	logic txShiftBusy = 1'b0;
	logic [4:0] rxLevel = 5'h0, txLevel = 5'h1;
	logic [7:0] rxData = 8'h0, modemStatus = 8'h0;
	logic [3:0] lineErrBits = 4'h0;
	int n_mismatch = 0, n_compared = 0, nPops = 0, nClr = 0;

	uart_irq_core uart_irq_core_inst (.clk, .reset, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hrdata, .hreadyout, .hresp, .rxPush, .rxLevel, .rxData, .rxFifoErr,
		.lineErrEvent, .lineErrBits, .txLevel, .txShiftBusy, .modemChange, .modemStatus, .baudTick,
		.rxRead, .txWrite, .txData, .fifoOn, .rxFifoClear, .txFifoClear, .wordLen, .txStopHalves, .irqOut);
	host_bus_model host_bus_model_inst (.clk, .hready(hreadyout), .hrdata, .hsel, .haddr, .htrans,
		.hwrite, .hsize, .hwdata);

	// 10 MHz clock
	always #50 clk = ~clk;

	// count receive pops and keep the last byte handed to the transmitter
	always @(posedge clk) begin
		if (rxRead === 1'b1) nPops++;
		if (txWrite === 1'b1) lastTx <= txData;
		if (rxFifoClear === 1'b1 && txFifoClear === 1'b1) nClr++;
	end

	task automatic step(input int n);
		repeat (n) @(posedge clk);
	endtask

	// baud ticks with a chosen gap, so time-outs count ticks, not clocks
	task automatic tick(input int n, input int g);
		repeat (n) begin
			baudTick <= 1'b1;
			step(1);
			baudTick <= 1'b0;
			step(g);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		logic [31:0] q;
		host_bus_model_inst.xfer(1'b1, a, {24'h0, v}, q);
	endtask

	// masked read compare; bits above the byte must read zero
	task automatic chk_rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
		logic [31:0] q;
		host_bus_model_inst.xfer(1'b0, a, 32'h0, q);
		`CHK(q & {24'hffffff, m}, {24'h0, e})
	endtask

	task automatic push(input logic [4:0] lvl);
		rxLevel <= lvl;
		rxPush <= 1'b1;
		step(1);
		rxPush <= 1'b0;
		step(3);
	endtask

	function automatic logic [2:0] halves(input logic [7:0] f);
		return !f[2] ? 3'h2 : (f[1:0] == 2'h0 ? 3'h3 : 3'h4);
	endfunction

	function automatic logic [7:0] iid(input logic fifo, input logic [3:0] c);
		return {fifo, fifo, 2'h0, c};
	endfunction

	task automatic give_verdict();
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// watchdog well beyond the expected run of some 7000 cycles
	initial begin
		step(40000);
		n_mismatch++;
		give_verdict();
	end

	initial begin
		logic [7:0] v, ms, rb;
		void'($urandom(5656));
		step(5);
		reset <= 1'b0;
		step(2);
		wr(`A_IEN, 8'hff);
		chk_rd(`A_IEN, 8'hff, 8'h0f);
		chk_rd(8'h1c, 8'hff, 8'h00);
		chk_rd(`A_IID, 8'hff, iid(0, 4'h1));
		`CHK(irqOut, 1'b0)
		`CHK(hresp, 1'b0)
		`CHK(hreadyout, 1'b1)
		// modem, then line error, then received data stacked up
		ms = 8'($urandom);
		modemStatus <= ms;
		modemChange <= 1'b1;
		step(1);
		modemChange <= 1'b0;
		step(3);
		chk_rd(`A_IID, 8'hff, iid(0, 4'h0));
		`CHK(irqOut, 1'b1)
		lineErrBits <= 4'h2;
		lineErrEvent <= 1'b1;
		step(1);
		lineErrEvent <= 1'b0;
		rb = 8'($urandom);
		rxData <= rb;
		push(5'h01);
		chk_rd(`A_IID, 8'hff, iid(0, 4'h6));
		chk_rd(`A_LST, 8'hff, 8'h05);
		chk_rd(`A_IID, 8'hff, iid(0, 4'h4));
		chk_rd(`A_DATA, 8'hff, rb);
		rxLevel <= 5'h00;
		step(2);
		`CHK(nPops, 1)
		chk_rd(`A_IID, 8'hff, iid(0, 4'h0));
		chk_rd(`A_MST, 8'hff, ms);
		chk_rd(`A_IID, 8'hff, iid(0, 4'h1));
		// holding register empties, cleared once by read and once by write
		txLevel <= 5'h00;
		step(3);
		chk_rd(`A_IID, 8'hff, iid(0, 4'h2));
		chk_rd(`A_IID, 8'hff, iid(0, 4'h1));
		chk_rd(`A_LST, 8'hff, 8'h60);
		txShiftBusy <= 1'b1;
		step(1);
		chk_rd(`A_LST, 8'h60, 8'h20);
		txShiftBusy <= 1'b0;
		v = 8'($urandom);
		txLevel <= 5'h01;
		step(2);
		txLevel <= 5'h00;
		step(3);
		wr(`A_DATA, v);
		step(2);
		`CHK(lastTx, v)
		chk_rd(`A_IID, 8'hff, iid(0, 4'h1));
		// every word length and stop select, random upper bits
		for (int i = 0; i < 8; i++) begin
			v = {5'($urandom), 3'(i)};
			wr(`A_LFC, v);
			chk_rd(`A_LFC, 8'hff, v);
			`CHK(wordLen, v[1:0])
			`CHK(txStopHalves, halves(v))
		end
		// fifo mode, trigger 14; first empty after the switch is immediate
		wr(`A_LFC, 8'h03);
		txLevel <= 5'h01;
		step(2);
		wr(`A_IID, 8'hc1);
		txLevel <= 5'h00;
		step(4);
		`CHK(fifoOn, 1'b1)
		`CHK(nClr, 1)
		chk_rd(`A_IID, 8'hff, iid(1, 4'h2));
		chk_rd(`A_IID, 8'hff, iid(1, 4'h1));
		// self-clearing fifo clears without a mode change
		wr(`A_IID, 8'hc7);
		step(2);
		`CHK(nClr, 2)
		txLevel <= 5'h01;
		step(2);
		txLevel <= 5'h00;
		tick(TXD - 10, 1);
		chk_rd(`A_LST, 8'h20, 8'h00);
		tick(20, 1);
		chk_rd(`A_LST, 8'h20, 8'h20);
		chk_rd(`A_IID, 8'hff, iid(1, 4'h2));
		chk_rd(`A_IID, 8'hff, iid(1, 4'h1));
		txLevel <= 5'h02;
		step(2);
		txLevel <= 5'h01;
		step(2);
		txLevel <= 5'h00;
		step(3);
		chk_rd(`A_LST, 8'h20, 8'h20);
		chk_rd(`A_IID, 8'hff, iid(1, 4'h2));
		push(5'h0d);
		chk_rd(`A_IID, 8'hff, iid(1, 4'h1));
		push(5'h0e);
		chk_rd(`A_IID, 8'hff, iid(1, 4'h4));
		rxLevel <= 5'h0d;
		step(3);
		chk_rd(`A_IID, 8'hff, iid(1, 4'h1));
		// character time-out, its clearing read and restart by a new byte
		push(5'h01);
		tick(TMO - 10, 1);
		chk_rd(`A_IID, 8'hff, iid(1, 4'h1));
		tick(20, 1);
		chk_rd(`A_IID, 8'hff, iid(1, 4'hc));
		`CHK(irqOut, 1'b1)
		chk_rd(`A_DATA, 8'hff, rb);
		chk_rd(`A_IID, 8'hff, iid(1, 4'h1));
		tick(TMO / 2, 3);
		push(5'h02);
		tick(TMO - 10, 3);
		chk_rd(`A_IID, 8'hff, iid(1, 4'h1));
		tick(20, 3);
		chk_rd(`A_IID, 8'hff, iid(1, 4'hc));
		chk_rd(`A_DATA, 8'hff, rb);
		// polled mode: no time-out, status still visible
		wr(`A_IEN, 8'h00);
		rxFifoErr <= 1'b1;
		tick(TMO + 20, 1);
		chk_rd(`A_IID, 8'hff, iid(1, 4'h1));
		`CHK(irqOut, 1'b0)
		chk_rd(`A_LST, 8'h81, 8'h81);
		give_verdict();
	end
endmodule
